// ### scs_pkg.sv
// constants for the serial channel setup block
package scs_pkg;
	// ====================================================================
	// register byte offsets
	localparam logic [7:0] OFS_CLK_GATE   = 8'h00;
	localparam logic [7:0] OFS_PRESCALE   = 8'h04;
	localparam logic [7:0] OFS_MODE       = 8'h08;
	localparam logic [7:0] OFS_COMM       = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
	localparam logic [7:0] OFS_TRIGGER    = 8'h18;
	localparam logic [7:0] OFS_STATE      = 8'h1c;
	// ====================================================================
	// field positions
	localparam int GATE_UNIT_BIT  = 2;
	localparam int PRS_A_LSB      = 0;
	localparam int PRS_B_LSB      = 4;
	localparam int MODE_OPCLK_BIT = 15;
	localparam int MODE_XFER_BIT  = 14;
	localparam int MODE_TRIG_BIT  = 8;
	localparam int MODE_FLD_LSB   = 1;
	localparam int MODE_IRQ_BIT   = 0;
	localparam int COMM_TX_BIT    = 15;
	localparam int COMM_RX_BIT    = 14;
	localparam int COMM_EOC_BIT   = 10;
	localparam int COMM_PAR_LSB   = 8;
	localparam int COMM_DIR_BIT   = 7;
	localparam int COMM_STOP_LSB  = 4;
	localparam int COMM_LEN_LSB   = 0;
	localparam int IRQ_CHAN_BIT   = 0;
	localparam int IRQ_ERR_BIT    = 1;
	localparam int IRQ_START_BIT  = 2;
	// ====================================================================
	// reset values and writable masks
	localparam logic [7:0]  GATE_RST  = 8'h00;
	localparam logic [7:0]  GATE_WMSK = 8'hbd;
	localparam logic [15:0] PRS_RST   = 16'h0000;
	localparam logic [15:0] PRS_WMSK  = 16'h00ff;
	localparam logic [15:0] MODE_RST  = 16'h0020;
	localparam logic [15:0] MODE_WMSK = 16'hc107;
	localparam logic [15:0] MODE_FIX  = 16'h0020;
	localparam logic [15:0] COMM_RST  = 16'h0007;
	localparam logic [15:0] COMM_WMSK = 16'hf7b3;
	localparam logic [15:0] COMM_FIX  = 16'h0004;
	// ====================================================================
	// codes and counts
	localparam logic [1:0] MODE_CSI  = 2'h0;
	localparam logic [1:0] MODE_UART = 2'h1;
	localparam logic [1:0] MODE_IIC  = 2'h2;
	localparam logic [1:0] MODE_BAD  = 2'h3;
	localparam logic [1:0] LEN_9     = 2'h1;
	localparam logic [1:0] LEN_7     = 2'h2;
	localparam logic [1:0] LEN_8     = 2'h3;
	localparam logic [1:0] STOP_BAD  = 2'h3;
	localparam logic [3:0] PRS_MAX   = 4'hc;
endpackage

// ### scs_channel.sv
// serial channel setup: clock gate, prescalers, mode and comm config
//
// Operation
// - unit clock gate bit stops or supplies the unit clock.
// - two 4-bit prescale codes, code k divides system clock by 2^k, k<=12.
// - mode bit 15 picks prescaled clock a (0) or b (1).
// - mode bit 14 picks divided op clock (0) or serial clock pin (1).
// - mode bit 8: software trigger only, or receive pin edge in UART.
// - mode field 00 clocked serial, 01 UART, 10 I2C, 11 forbidden.
// - mode bit 0: irq at transfer end (0) or buffer empty (1).
// - tx/rx enables: off, receive, transmit or full duplex.
// - comm bit 10 unmasks the channel error interrupt.
// - UART parity: none, zero unchecked, even, odd.
// - comm bit 7: msb first (0) or lsb first (1).
// - clocked serial length: 01 nine bits, 11 eight bits, others forbidden.
// - UART stop bits: none, one, two; 11 forbidden.
`timescale 1ns/1ps
module scs_channel #(
	parameter int PRESCALE_BITS = 12
) (
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_B_IN,
	input  wire logic [7:0]  ADDR_IN,
	input  wire logic [31:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [31:0] RDATA_OUT,
	input  wire logic        SCK_IN,
	input  wire logic        RXD_IN,
	output logic             UNIT_CLK_EN_OUT,
	output logic             XFER_TICK_OUT,
	output logic             START_OUT,
	output logic             BUSY_OUT,
	output logic             TX_EN_OUT,
	output logic             RX_EN_OUT,
	output logic      [1:0]  MODE_OUT,
	output logic      [1:0]  PARITY_OUT,
	output logic             LSB_FIRST_OUT,
	output logic      [1:0]  STOP_BITS_OUT,
	output logic      [3:0]  WORD_BITS_OUT,
	output logic             ERROR_IRQ_OUT,
	output logic             IRQ_OUT
);
	// ====================================================================
	// state
	typedef struct packed {
		logic [7:0]               gate;
		logic [15:0]              prs;
		logic [15:0]              mode;
		logic [15:0]              comm;
		logic [2:0]               ists;
		logic [2:0]               imsk;
		logic [PRESCALE_BITS-1:0] pcnt;
		logic                     busy;
		logic [3:0]               bcnt;
		logic [3:0]               wbits;
		logic                     sck_d;
		logic                     rxd_d;
		logic                     cfg_err_d;
		logic                     tick;
		logic                     start;
		logic                     err_irq;
		logic                     irq;
		logic [31:0]              rdata;
	} scs_state_t;

	scs_state_t s_reg;
	scs_state_t s_next;
	logic       rst_meta_reg;
	logic       rst_sync_reg;

	// ====================================================================
	// helpers
	// one-cycle enable of a prescaled clock: all low k bits set
	function automatic logic prs_tick(input logic [3:0] code,
			input logic [PRESCALE_BITS-1:0] cnt);
		logic [PRESCALE_BITS-1:0] msk;
		logic [3:0]               k;
		k = (code > scs_pkg::PRS_MAX) ? scs_pkg::PRS_MAX : code;
		msk = ~({PRESCALE_BITS{1'b1}} << k);
		return (cnt & msk) == msk;
	endfunction

	// data bits per word from the length field
	function automatic logic [3:0] len_bits(input logic [1:0] len);
		case (len)
			scs_pkg::LEN_9: len_bits = 4'h9;
			scs_pkg::LEN_7: len_bits = 4'h7;
			default:        len_bits = 4'h8;
		endcase
	endfunction

	// ====================================================================
	// reset release through two flops
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ====================================================================
	// decoded configuration
	logic       gate_on;
	logic       op_tick;
	logic       xfer_tick;
	logic       sck_rise;
	logic       rxd_fall;
	logic       sw_trig;
	logic       start_req;
	logic       cfg_err;
	logic       last_bit;
	logic [3:0] frame_bits;
	logic [1:0] mode_fld;
	logic [2:0] ev;

	always_comb begin
		gate_on  = s_reg.gate[scs_pkg::GATE_UNIT_BIT];
		mode_fld = s_reg.mode[scs_pkg::MODE_FLD_LSB +: 2];
		// op clock: prescaled clock a or b, stopped with the gate
		op_tick = gate_on && (s_reg.mode[scs_pkg::MODE_OPCLK_BIT]
			? prs_tick(s_reg.prs[scs_pkg::PRS_B_LSB +: 4], s_reg.pcnt)
			: prs_tick(s_reg.prs[scs_pkg::PRS_A_LSB +: 4], s_reg.pcnt));
		sck_rise = SCK_IN && !s_reg.sck_d;
		rxd_fall = !RXD_IN && s_reg.rxd_d;
		// pin clock is only honoured while the unit is clocked
		xfer_tick = gate_on && (s_reg.mode[scs_pkg::MODE_XFER_BIT]
			? sck_rise : op_tick);
		sw_trig = WR_IN && ADDR_IN == scs_pkg::OFS_TRIGGER && WDATA_IN[0];
		start_req = gate_on && (sw_trig
			|| (s_reg.mode[scs_pkg::MODE_TRIG_BIT]
			&& mode_fld == scs_pkg::MODE_UART && rxd_fall));
		// forbidden encodings flag a setup error
		cfg_err = mode_fld == scs_pkg::MODE_BAD
			|| (mode_fld == scs_pkg::MODE_CSI
			&& s_reg.comm[scs_pkg::COMM_LEN_LSB +: 2] != scs_pkg::LEN_9
			&& s_reg.comm[scs_pkg::COMM_LEN_LSB +: 2] != scs_pkg::LEN_8)
			|| (mode_fld == scs_pkg::MODE_UART
			&& s_reg.comm[scs_pkg::COMM_STOP_LSB +: 2] == scs_pkg::STOP_BAD);
		// UART frame adds start, parity and stop bits
		frame_bits = s_reg.wbits;
		if (mode_fld == scs_pkg::MODE_UART) begin
			frame_bits = 4'(s_reg.wbits + 4'h1
				+ {3'h0, s_reg.comm[scs_pkg::COMM_PAR_LSB +: 2] != 2'h0}
				+ {2'h0, s_reg.comm[scs_pkg::COMM_STOP_LSB +: 2]});
		end
		last_bit = 4'(s_reg.bcnt + 4'h1) >= frame_bits;
	end

	// ====================================================================
	// next state
	always_comb begin
		s_next = s_reg;
		ev     = 3'h0;
		s_next.sck_d     = SCK_IN;
		s_next.rxd_d     = RXD_IN;
		s_next.cfg_err_d = cfg_err;
		// counter frozen while the unit clock is stopped
		if (gate_on) begin
			s_next.pcnt = s_reg.pcnt + PRESCALE_BITS'(1);
		end
		s_next.tick  = xfer_tick;
		s_next.start = 1'b0;
		// register writes; fixed bits are forced
		if (WR_IN) begin
			case (ADDR_IN)
				scs_pkg::OFS_CLK_GATE:
					s_next.gate = WDATA_IN[7:0] & scs_pkg::GATE_WMSK;
				scs_pkg::OFS_PRESCALE:
					s_next.prs = WDATA_IN[15:0] & scs_pkg::PRS_WMSK;
				scs_pkg::OFS_MODE:
					s_next.mode = (WDATA_IN[15:0] & scs_pkg::MODE_WMSK)
						| scs_pkg::MODE_FIX;
				scs_pkg::OFS_COMM:
					s_next.comm = (WDATA_IN[15:0] & scs_pkg::COMM_WMSK)
						| scs_pkg::COMM_FIX;
				scs_pkg::OFS_IRQ_STATUS:
					s_next.ists = s_reg.ists & ~WDATA_IN[2:0];
				scs_pkg::OFS_IRQ_MASK:
					s_next.imsk = WDATA_IN[2:0];
				default: ;
			endcase
		end
		// transfer: needs at least one direction enabled
		if (!s_reg.busy) begin
			if (start_req && (s_reg.comm[scs_pkg::COMM_TX_BIT]
					|| s_reg.comm[scs_pkg::COMM_RX_BIT])) begin
				s_next.busy  = 1'b1;
				s_next.bcnt  = 4'h0;
				s_next.start = 1'b1;
				// word size latched at start so a rewrite cannot cut a word
				s_next.wbits = len_bits(
					s_reg.comm[scs_pkg::COMM_LEN_LSB +: 2]);
				ev[scs_pkg::IRQ_START_BIT] = 1'b1;
				// buffer drained into the shifter when transmitting
				if (s_reg.mode[scs_pkg::MODE_IRQ_BIT]
						&& s_reg.comm[scs_pkg::COMM_TX_BIT]) begin
					ev[scs_pkg::IRQ_CHAN_BIT] = 1'b1;
				end
			end
		end else if (xfer_tick) begin
			s_next.bcnt = s_reg.bcnt + 4'h1;
			if (last_bit) begin
				s_next.busy = 1'b0;
				// transfer end event
				if (!s_reg.mode[scs_pkg::MODE_IRQ_BIT]) begin
					ev[scs_pkg::IRQ_CHAN_BIT] = 1'b1;
				end
			end
		end
		if (cfg_err && !s_reg.cfg_err_d) begin
			ev[scs_pkg::IRQ_ERR_BIT] = 1'b1;
		end
		// set wins over a clear in the same cycle
		s_next.ists = s_next.ists | ev;
		// error line follows the error flag only when unmasked
		s_next.err_irq = cfg_err && s_reg.comm[scs_pkg::COMM_EOC_BIT];
		// new mask taken at once so the line never lags a mask write
		s_next.irq = |(s_next.ists & s_next.imsk);
		// read data stand one cycle; unmapped reads return zero
		s_next.rdata = 32'h0;
		if (RD_IN) begin
			case (ADDR_IN)
				scs_pkg::OFS_CLK_GATE:   s_next.rdata = {24'h0, s_reg.gate};
				scs_pkg::OFS_PRESCALE:   s_next.rdata = {16'h0, s_reg.prs};
				scs_pkg::OFS_MODE:       s_next.rdata = {16'h0, s_reg.mode};
				scs_pkg::OFS_COMM:       s_next.rdata = {16'h0, s_reg.comm};
				scs_pkg::OFS_IRQ_STATUS: s_next.rdata = {29'h0, s_reg.ists};
				scs_pkg::OFS_IRQ_MASK:   s_next.rdata = {29'h0, s_reg.imsk};
				scs_pkg::OFS_STATE:
					s_next.rdata = {24'h0, s_reg.bcnt, 1'b0, cfg_err,
						gate_on, s_reg.busy};
				default:                 s_next.rdata = 32'h0;
			endcase
		end
	end

	// ====================================================================
	// state register
	always_ff @(posedge REF_CLK_IN or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			// edge detectors start at the idle-high pin level: no false edge
			s_reg <= '{gate: scs_pkg::GATE_RST, prs: scs_pkg::PRS_RST,
				mode: scs_pkg::MODE_RST, comm: scs_pkg::COMM_RST,
				wbits: 4'h8, sck_d: 1'b1, rxd_d: 1'b1, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// ====================================================================
	// outputs, all straight from the state flops
	assign RDATA_OUT       = s_reg.rdata;
	assign UNIT_CLK_EN_OUT = s_reg.gate[scs_pkg::GATE_UNIT_BIT];
	assign XFER_TICK_OUT   = s_reg.tick;
	assign START_OUT       = s_reg.start;
	assign BUSY_OUT        = s_reg.busy;
	assign TX_EN_OUT       = s_reg.comm[scs_pkg::COMM_TX_BIT];
	assign RX_EN_OUT       = s_reg.comm[scs_pkg::COMM_RX_BIT];
	assign MODE_OUT        = s_reg.mode[scs_pkg::MODE_FLD_LSB +: 2];
	assign PARITY_OUT      = s_reg.comm[scs_pkg::COMM_PAR_LSB +: 2];
	assign LSB_FIRST_OUT   = s_reg.comm[scs_pkg::COMM_DIR_BIT];
	assign STOP_BITS_OUT   = s_reg.comm[scs_pkg::COMM_STOP_LSB +: 2];
	assign WORD_BITS_OUT   = s_reg.wbits;
	assign ERROR_IRQ_OUT   = s_reg.err_irq;
	assign IRQ_OUT         = s_reg.irq;

	// ====================================================================
	// checks
	property p_gate_stops;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		!gate_on |=> !s_reg.tick && $stable(s_reg.pcnt);
	endproperty
	a_gate_stops: assert property (p_gate_stops)
		else $error("tick or prescaler moved with the unit clock stopped");

	property p_div_one;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		gate_on && s_reg.prs[3:0] == 4'h0
			&& !s_reg.mode[15] && !s_reg.mode[14] |=> s_reg.tick;
	endproperty
	a_div_one: assert property (p_div_one)
		else $error("code zero did not tick every cycle");

	property p_div_two_b;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		gate_on && s_reg.mode[15] && !s_reg.mode[14]
			&& s_reg.prs[7:4] == 4'h1 && $stable(s_reg.prs)
			&& $stable(s_reg.mode) && $stable(gate_on)
			|=> !(s_reg.tick && $past(s_reg.tick));
	endproperty
	a_div_two_b: assert property (p_div_two_b)
		else $error("clock b at code one ticked twice in a row");

	property p_pin_clock;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		gate_on && s_reg.mode[14] |=> s_reg.tick == $past(sck_rise);
	endproperty
	a_pin_clock: assert property (p_pin_clock)
		else $error("pin clock selected but tick not from pin edge");

	property p_no_hw_trig;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		!s_reg.mode[8] && !sw_trig |=> !s_reg.start;
	endproperty
	a_no_hw_trig: assert property (p_no_hw_trig)
		else $error("start without software trigger");

	property p_bad_mode;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		s_reg.mode[2:1] == 2'h3 && !s_reg.cfg_err_d |=> s_reg.ists[1];
	endproperty
	a_bad_mode: assert property (p_bad_mode)
		else $error("forbidden mode did not flag an error");

	property p_end_irq;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		s_reg.busy && xfer_tick && last_bit && !s_reg.mode[0]
			|=> !s_reg.busy && s_reg.ists[0];
	endproperty
	a_end_irq: assert property (p_end_irq)
		else $error("transfer end did not raise the channel event");

	property p_no_dir;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		!s_reg.busy && s_reg.comm[15:14] == 2'h0 |=> !s_reg.busy;
	endproperty
	a_no_dir: assert property (p_no_dir)
		else $error("transfer began with communication disabled");

	property p_err_mask;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		!s_reg.comm[10] |=> !s_reg.err_irq;
	endproperty
	a_err_mask: assert property (p_err_mask)
		else $error("error interrupt raised while masked");

	property p_len_nine;
		@(posedge REF_CLK_IN) disable iff (!rst_sync_reg)
		!s_reg.busy && start_req && s_reg.comm[15]
			&& s_reg.comm[1:0] == 2'h1 |=> s_reg.wbits == 4'h9;
	endproperty
	a_len_nine: assert property (p_len_nine)
		else $error("length code one did not give nine bits");
endmodule

// ### scs_master_model.sv
// behavioural model of the external clocked serial master
`timescale 1ns/1ps
module scs_master_model (
	input  wire logic clk_in,
	output logic      sck_out,
	output logic      rxd_out
);
	// ====================================================================
	// idle levels
	// both lines idle high: the clock stands still outside frames
	initial begin
		sck_out = 1'b1;
		rxd_out = 1'b1;
	end

	// ====================================================================
	// serial clock bursts, each level held for half system cycles
	task automatic pulse_clocks(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			repeat (half) @(posedge clk_in);
			sck_out <= 1'b0;
			repeat (half) @(posedge clk_in);
			sck_out <= 1'b1;
		end
	endtask

	// ====================================================================
	// one short low pulse on the data line, seen as a start edge
	task automatic start_bit();
		@(posedge clk_in);
		rxd_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		rxd_out <= 1'b1;
	endtask
endmodule

// ### tb.sv
// self-checking testbench of the serial channel setup block
`timescale 1ns/1ps
module tb;
	// ====================================================================
	// signals
	logic        ref_clk;
	logic        rst_b;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr_s;
	logic        rd_s;
	logic [31:0] rdata;
	logic        sck;
	logic        rxd;
	logic        clk_en;
	logic        tick;
	logic        start;
	logic        busy;
	logic        tx_en;
	logic        rx_en;
	logic [1:0]  mode;
	logic [1:0]  parity;
	logic        lsb_first;
	logic [1:0]  stop_bits;
	logic [3:0]  word_bits;
	logic        err_irq;
	logic        irq;
	int          n_fail = 0;
	int          check_count = 0;
	int          cycles = 0;

	scs_channel u_scs_channel (.REF_CLK_IN(ref_clk), .RST_B_IN(rst_b),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s),
		.RDATA_OUT(rdata), .SCK_IN(sck), .RXD_IN(rxd),
		.UNIT_CLK_EN_OUT(clk_en), .XFER_TICK_OUT(tick), .START_OUT(start),
		.BUSY_OUT(busy), .TX_EN_OUT(tx_en), .RX_EN_OUT(rx_en),
		.MODE_OUT(mode), .PARITY_OUT(parity), .LSB_FIRST_OUT(lsb_first),
		.STOP_BITS_OUT(stop_bits), .WORD_BITS_OUT(word_bits),
		.ERROR_IRQ_OUT(err_irq), .IRQ_OUT(irq));
	scs_master_model u_scs_master_model (.clk_in(ref_clk),
		.sck_out(sck), .rxd_out(rxd));

	// ====================================================================
	// clock and hang guard; ceiling well above the longest tick test
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_fail++;
			final_report();
		end
	end

	// ====================================================================
	// bus and compare tasks
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge ref_clk);
		wr_s <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
		input string what);
		@(posedge ref_clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge ref_clk);
		rd_s <= 1'b0;
		@(negedge ref_clk);
		chk(what, exp, rdata);
	endtask
	// third gap is clean even if the divider changed mid-count
	task automatic tick_gap(output int gap);
		for (int p = 0; p < 3; p++) begin
			gap = 0;
			do begin
				@(negedge ref_clk);
				gap++;
			end while (tick !== 1'b1 && gap < 5000);
		end
	endtask

	// ====================================================================
	// scenarios
	task automatic t_reset();
		@(negedge ref_clk);
		chk("word bits", 32'h8, word_bits);
		rchk(scs_pkg::OFS_MODE, 32'h20, "mode reg");
		rchk(scs_pkg::OFS_COMM, 32'h7, "comm reg");
		rchk(scs_pkg::OFS_PRESCALE, 32'h0, "prescale reg");
		rchk(8'h20, 32'h0, "unmapped");
	endtask
	task automatic t_gate();
		int n;
		n = 0;
		wr(scs_pkg::OFS_CLK_GATE, 32'hff);
		@(negedge ref_clk);
		chk("clock gate on", 32'h1, clk_en);
		rchk(scs_pkg::OFS_CLK_GATE, 32'hbd, "gate reg");
		wr(scs_pkg::OFS_CLK_GATE, 32'h0);
		// tick lags its enable by one cycle: skip the last one in flight
		@(negedge ref_clk);
		repeat (16) begin
			@(negedge ref_clk);
			n += (tick === 1'b1);
		end
		chk("ticks while gated", 32'h0, n);
		chk("clock gate off", 32'h0, clk_en);
		wr(scs_pkg::OFS_CLK_GATE, 32'h4);
	endtask
	task automatic t_prescale();
		int g;
		wr(scs_pkg::OFS_PRESCALE, 32'h52);
		tick_gap(g);
		chk("clock a period", 32'd4, g);
		wr(scs_pkg::OFS_MODE, 32'h8020);
		tick_gap(g);
		chk("clock b period", 32'd32, g);
		wr(scs_pkg::OFS_PRESCALE, 32'h12);
		tick_gap(g);
		chk("clock b code 1 period", 32'd2, g);
		wr(scs_pkg::OFS_MODE, 32'h0020);
		wr(scs_pkg::OFS_PRESCALE, 32'h0c);
		tick_gap(g);
		chk("code 12 period", 32'd4096, g);
		wr(scs_pkg::OFS_PRESCALE, 32'h00);
		tick_gap(g);
		chk("code 0 period", 32'd1, g);
	endtask
	task automatic t_sck();
		int g;
		wr(scs_pkg::OFS_MODE, 32'h4020);
		fork
			u_scs_master_model.pulse_clocks(6, 3);
			tick_gap(g);
		join
		chk("pin clock period", 32'd6, g);
	endtask
	task automatic t_fields();
		int c;
		for (int i = 0; i < 4; i++) begin
			c = (i << 14) | (i << 8) | ((i & 1) << 7) | (i << 4) | 32'h403;
			wr(scs_pkg::OFS_COMM, c);
			wr(scs_pkg::OFS_MODE, (i << 1) | 32'h20);
			repeat (2) @(negedge ref_clk);
			chk("mode field", i, mode);
			chk("comm fields", (i << 5) | (i << 3) | ((i & 1) << 2) | i,
				{tx_en, rx_en, parity, lsb_first, stop_bits});
			chk("error irq", i == 3, err_irq);
			rchk(scs_pkg::OFS_COMM, (c & 32'hf7b3) | 32'h4, "comm reg");
		end
		wr(scs_pkg::OFS_COMM, 32'h3);
		repeat (2) @(negedge ref_clk);
		chk("error irq masked", 32'h0, err_irq);
		wr(scs_pkg::OFS_MODE, 32'h20);
	endtask
	// pin clock gives an exact tick count for the frame length
	task automatic t_xfer(input logic [1:0] len, input logic on_empty);
		int nb;
		nb = (len == scs_pkg::LEN_9) ? 9 : 8;
		wr(scs_pkg::OFS_IRQ_STATUS, 32'h7);
		wr(scs_pkg::OFS_MODE, 32'h4020 | on_empty);
		wr(scs_pkg::OFS_COMM, 32'h8004 | len);
		wr(scs_pkg::OFS_IRQ_MASK, 32'h1);
		wr(scs_pkg::OFS_TRIGGER, 32'h1);
		@(negedge ref_clk);
		chk("start and busy", 32'h3, {start, busy});
		@(negedge ref_clk);
		chk("word bits", nb, word_bits);
		chk("irq at start", on_empty, irq);
		u_scs_master_model.pulse_clocks(nb - 1, 2);
		repeat (3) @(negedge ref_clk);
		chk("busy before last bit", 32'h1, busy);
		u_scs_master_model.pulse_clocks(1, 2);
		repeat (3) @(negedge ref_clk);
		chk("busy after last bit", 32'h0, busy);
		chk("irq after frame", 32'h1, irq);
		rchk(scs_pkg::OFS_IRQ_STATUS, 32'h5, "status");
		wr(scs_pkg::OFS_IRQ_MASK, 32'h0);
		@(negedge ref_clk);
		chk("irq masked", 32'h0, irq);
		wr(scs_pkg::OFS_IRQ_STATUS, 32'h5);
		wr(scs_pkg::OFS_IRQ_MASK, 32'h1);
		@(negedge ref_clk);
		chk("irq cleared", 32'h0, irq);
	endtask
	task automatic t_trigger();
		logic seen;
		for (int s = 0; s < 2; s++) begin
			seen = 1'b0;
			wr(scs_pkg::OFS_MODE, (s << 8) | 32'h22);
			wr(scs_pkg::OFS_COMM, 32'h4017);
			fork
				u_scs_master_model.start_bit();
				repeat (10) begin
					@(negedge ref_clk);
					if (start === 1'b1)
						seen = 1'b1;
				end
			join
			chk("start on data edge", s, seen);
			repeat (40) @(negedge ref_clk);
		end
	endtask

	// ====================================================================
	// verdict and main sequence
	task automatic final_report();
		if (n_fail == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		addr = 8'h00;
		wdata = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		rst_b = 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_gate();
		t_prescale();
		t_sck();
		t_fields();
		t_xfer(scs_pkg::LEN_8, 1'b0);
		t_xfer(scs_pkg::LEN_9, 1'b1);
		t_trigger();
		final_report();
	end
endmodule
